/* File: design/acrd_detector.v */
// Purpose: Measures audio clocks and reports rates and clock health
// Assumes: Audio clocks sampled by the 20 MHz clock; master clock
//          below 10 MHz to be counted exactly
// Notes: Measurement closes at each frame clock rising edge
// Notes on behaviour
// - Sample rate class reported as 3-bit code, 000 meaning out of range.
// - Master clock ratio reported as 4-bit code, 0000 meaning disallowed.
// - Clock error may flag when ratio valid but incompatible with rate.
// - Without PLL, ratio must leave enough processing cycles, else error.
// - Bit clocks per frame counted as 9 bits split over two registers.
// - Bit count unreliable at one bit clock per frame.
// - Health bit 6 master clock halted, bit 4 frame and bit clock missing.
// - Health bit 5 PLL unlocked, also set when PLL disabled.
// - Bit 1 set unless bit clock ratio stable within 32 to 256.
// - Bit 2 set when ratio undetectable or frame low phase five or less.
`timescale 1ns/1ps
`include "acrd_regs.vh"
module acrd_detector (
	input wire clock,
	input wire rst,
	input wire mclkPin,
	input wire bclkPin,
	input wire lrclkPin,
	input wire pllEnable,
	input wire pllLocked,
	input wire rdEn,
	input wire [7:0] rdAddr,
	input wire wrEn,
	input wire [7:0] wrAddr,
	input wire [7:0] wrData,
	output reg [7:0] rdData_q
);
	// ==========================================================
	// Helpers
	function near;
		input [11:0] cnt;
		input [11:0] val;
		begin
			near = (cnt + 12'h001 >= val) && (cnt <= val + 12'h001);
		end
	endfunction

	function [3:0] ratioCode;
		input [11:0] c;
		begin
			if (near(c, 12'h020)) ratioCode = 4'h1;
			else if (near(c, 12'h030)) ratioCode = 4'h2;
			else if (near(c, 12'h040)) ratioCode = 4'h3;
			else if (near(c, 12'h080)) ratioCode = 4'h4;
			else if (near(c, 12'h0C0)) ratioCode = 4'h5;
			else if (near(c, 12'h100)) ratioCode = 4'h6;
			else if (near(c, 12'h180)) ratioCode = 4'h7;
			else if (near(c, 12'h200)) ratioCode = 4'h8;
			else if (near(c, 12'h300)) ratioCode = 4'h9;
			else if (near(c, 12'h400)) ratioCode = 4'hA;
			else if (near(c, 12'h480)) ratioCode = 4'hB;
			else if (near(c, 12'h600)) ratioCode = 4'hC;
			else if (near(c, 12'h800)) ratioCode = 4'hD;
			else ratioCode = 4'h0;
		end
	endfunction

	function [2:0] rateCode;
		input [11:0] f;
		begin
			if (f >= `ACRD_F8K_LO && f <= `ACRD_F8K_HI)
				rateCode = `ACRD_FS_8K;
			else if (f >= `ACRD_F16K_LO && f <= `ACRD_F16K_HI)
				rateCode = `ACRD_FS_16K;
			else if (f >= `ACRD_F48K_LO && f <= `ACRD_F48K_HI)
				rateCode = `ACRD_FS_48K;
			else if (f >= `ACRD_F96K_LO && f <= `ACRD_F96K_HI)
				rateCode = `ACRD_FS_96K;
			else if (f >= `ACRD_F192K_LO && f <= `ACRD_F192K_HI)
				rateCode = `ACRD_FS_192K;
			else if (f >= `ACRD_F384K_LO && f <= `ACRD_F384K_HI)
				rateCode = `ACRD_FS_384K;
			else
				rateCode = `ACRD_FS_ERR;
		end
	endfunction

	function [11:0] sat12;
		input [11:0] v;
		begin
			sat12 = (v == 12'hFFF) ? v : v + 12'h001;
		end
	endfunction

	// ==========================================================
	// Clock inputs
	wire mclkRise, bclkLvl, bclkRise, lrLvl, lrRise;

	acrd_sync_edge uMclk (
		.clock(clock),
		.rst(rst),
		.pinIn(mclkPin),
		.level(),
		.rise(mclkRise)
	);
	acrd_sync_edge uBclk (
		.clock(clock),
		.rst(rst),
		.pinIn(bclkPin),
		.level(bclkLvl),
		.rise(bclkRise)
	);
	acrd_sync_edge uLrclk (
		.clock(clock),
		.rst(rst),
		.pinIn(lrclkPin),
		.level(lrLvl),
		.rise(lrRise)
	);

	// ==========================================================
	// Per-frame counters and results
	reg [11:0] sysCnt_q, mclkCnt_q;
	reg [8:0] bclkCnt_q, lowBclk_q, lastBclk_q;
	reg started_q, stable_q;
	reg [2:0] rate_q;
	reg [3:0] mRatio_q;
	reg [11:0] mRaw_q;
	reg [8:0] bCount_q;
	reg shortLow_q;
	reg [11:0] haltCnt_q, missCnt_q;
	reg mclkHalt_q, frameMiss_q;
	reg rsvRate_q, rsvHealth_q;
	reg [6:0] rsvHi_q;

	wire [11:0] dspRatio = mRaw_q;
	wire comboErr = (mRatio_q != 4'h0) &&
		((rate_q == `ACRD_FS_ERR) ||
		(!pllEnable && dspRatio < `ACRD_MIN_DSP_RATIO));
	wire pllUnlocked = ~pllEnable | ~pllLocked;
	wire bclkInvalid = ~stable_q || bCount_q < `ACRD_BCLK_MIN ||
		bCount_q > `ACRD_BCLK_MAX;
	wire mclkInvalid = (mRatio_q == 4'h0) || shortLow_q;
	wire [7:0] healthByte = {rsvHealth_q, mclkHalt_q, pllUnlocked,
		frameMiss_q, comboErr, mclkInvalid, bclkInvalid, 1'b0};

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sysCnt_q <= 12'h000;
			mclkCnt_q <= 12'h000;
			bclkCnt_q <= 9'h000;
			lowBclk_q <= 9'h000;
			lastBclk_q <= 9'h000;
			started_q <= 1'b0;
			stable_q <= 1'b0;
			rate_q <= 3'h0;
			mRatio_q <= 4'h0;
			mRaw_q <= 12'h000;
			bCount_q <= 9'h000;
			shortLow_q <= 1'b0;
		end else if (frameMiss_q) begin
			// Frames have stopped: results fall back to zero
			started_q <= 1'b0;
			stable_q <= 1'b0;
			rate_q <= 3'h0;
			mRatio_q <= 4'h0;
			mRaw_q <= 12'h000;
			bCount_q <= 9'h000;
			shortLow_q <= 1'b0;
			sysCnt_q <= 12'h000;
			mclkCnt_q <= 12'h000;
			bclkCnt_q <= 9'h000;
			lowBclk_q <= 9'h000;
		end else if (lrRise) begin
			started_q <= 1'b1;
			if (started_q) begin
				rate_q <= rateCode(sysCnt_q);
				mRatio_q <= ratioCode(mclkCnt_q);
				mRaw_q <= mclkCnt_q;
				bCount_q <= bclkCnt_q;
				lastBclk_q <= bclkCnt_q;
				stable_q <= (bclkCnt_q == lastBclk_q);
				shortLow_q <= (lowBclk_q <= `ACRD_LR_LOW_MIN);
			end
			sysCnt_q <= 12'h001;
			mclkCnt_q <= {11'h000, mclkRise};
			bclkCnt_q <= {8'h00, bclkRise};
			lowBclk_q <= 9'h000;
		end else begin
			sysCnt_q <= sat12(sysCnt_q);
			if (mclkRise)
				mclkCnt_q <= sat12(mclkCnt_q);
			if (bclkRise && bclkCnt_q != 9'h1FF)
				bclkCnt_q <= bclkCnt_q + 9'h001;
			if (bclkRise && !lrLvl && lowBclk_q != 9'h1FF)
				lowBclk_q <= lowBclk_q + 9'h001;
		end
	end

	// ==========================================================
	// Halt and missing-clock watchdogs
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			haltCnt_q <= 12'h000;
			missCnt_q <= 12'h000;
			mclkHalt_q <= 1'b0;
			frameMiss_q <= 1'b0;
		end else begin
			if (mclkRise) begin
				haltCnt_q <= 12'h000;
				mclkHalt_q <= 1'b0;
			end else if (haltCnt_q >= `ACRD_HALT_CYC - 1) begin
				mclkHalt_q <= 1'b1;
			end else begin
				haltCnt_q <= haltCnt_q + 12'h001;
			end
			if (bclkLvl || lrLvl) begin
				missCnt_q <= 12'h000;
				frameMiss_q <= 1'b0;
			end else if (missCnt_q >= `ACRD_MISS_CYC - 1) begin
				frameMiss_q <= 1'b1;
			end else begin
				missCnt_q <= missCnt_q + 12'h001;
			end
		end
	end

	// ==========================================================
	// Register port: reserved bits hold writes, status is read only
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rsvRate_q <= 1'b0;
			rsvHealth_q <= 1'b0;
			rsvHi_q <= `ACRD_RST_RSV_HI;
			rdData_q <= `ACRD_RST_BYTE;
		end else begin
			if (wrEn) begin
				case (wrAddr)
					`ACRD_OFS_RATE: rsvRate_q <= wrData[`ACRD_RSV_BIT];
					`ACRD_OFS_BCNT_HI: rsvHi_q <= wrData[7:1];
					`ACRD_OFS_HEALTH: rsvHealth_q <= wrData[`ACRD_RSV_BIT];
					default: rsvHi_q <= rsvHi_q;
				endcase
			end
			if (rdEn) begin
				case (rdAddr)
					`ACRD_OFS_RATE: rdData_q <= {rsvRate_q, rate_q, mRatio_q};
					`ACRD_OFS_BCNT_HI: rdData_q <= {rsvHi_q, bCount_q[8]};
					`ACRD_OFS_BCNT_LO: rdData_q <= bCount_q[7:0];
					`ACRD_OFS_HEALTH: rdData_q <= healthByte;
					default: rdData_q <= `ACRD_RST_BYTE;
				endcase
			end
		end
	end
endmodule

/* File: design/acrd_regs.vh */
// Purpose: Constants for the audio clock rate detector
// Assumes: 20 MHz system clock
// Notes: Register offsets, field positions, reset values and timing counts
`ifndef ACRD_REGS_VH
`define ACRD_REGS_VH

// ==========================================================
// Register offsets
`define ACRD_OFS_RATE 8'h5B
`define ACRD_OFS_BCNT_HI 8'h5C
`define ACRD_OFS_BCNT_LO 8'h5D
`define ACRD_OFS_HEALTH 8'h5E

// ==========================================================
// Field positions
`define ACRD_RATE_CODE_MSB 6
`define ACRD_RATE_CODE_LSB 4
`define ACRD_MRATIO_MSB 3
`define ACRD_MRATIO_LSB 0
`define ACRD_HB_MCLK_HALT 6
`define ACRD_HB_PLL_UNLOCK 5
`define ACRD_HB_FRAME_MISS 4
`define ACRD_HB_COMBO_ERR 3
`define ACRD_HB_MCLK_INV 2
`define ACRD_HB_BCLK_INV 1
`define ACRD_RSV_BIT 7

// ==========================================================
// Reset values
`define ACRD_RST_BYTE 8'h00
`define ACRD_RST_RSV_HI 7'h00

// ==========================================================
// Rate codes
`define ACRD_FS_ERR 3'h0
`define ACRD_FS_8K 3'h1
`define ACRD_FS_16K 3'h2
`define ACRD_FS_48K 3'h3
`define ACRD_FS_96K 3'h4
`define ACRD_FS_192K 3'h5
`define ACRD_FS_384K 3'h6

// Frame length windows, in system clock cycles
`define ACRD_F8K_LO 12'h947
`define ACRD_F8K_HI 12'hA41
`define ACRD_F16K_LO 12'h4A4
`define ACRD_F16K_HI 12'h521
`define ACRD_F48K_LO 12'h190
`define ACRD_F48K_HI 12'h28A
`define ACRD_F96K_LO 12'h0C8
`define ACRD_F96K_HI 12'h0EB
`define ACRD_F192K_LO 12'h064
`define ACRD_F192K_HI 12'h076
`define ACRD_F384K_LO 12'h032
`define ACRD_F384K_HI 12'h036

// ==========================================================
// Bit clock limits and low-phase limit
`define ACRD_BCLK_MIN 9'h020
`define ACRD_BCLK_MAX 9'h100
`define ACRD_LR_LOW_MIN 9'h005
// Least master clocks per sample for processing without the PLL
`define ACRD_MIN_DSP_RATIO 12'h100

// ==========================================================
// Timing
`define ACRD_CLK_MHZ 20
`define ACRD_HALT_NS 2000
`define ACRD_HALT_CYC ((`ACRD_HALT_NS * `ACRD_CLK_MHZ) / 1000)
`define ACRD_MISS_NS 100000
`define ACRD_MISS_CYC ((`ACRD_MISS_NS * `ACRD_CLK_MHZ) / 1000)

`endif

/* File: design/acrd_sync_edge.v */
// Purpose: Two-flop synchroniser with rising edge pulse
// Assumes: Input is asynchronous to clock
// Notes: Only the second stage feeds the edge detector
`timescale 1ns/1ps
module acrd_sync_edge (
	input wire clock,
	input wire rst,
	input wire pinIn,
	output wire level,
	output wire rise
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
endmodule

/* File: verification/acrd_detector_props.sv */
// Purpose: Checker for the audio clock rate detector ports
// Assumes: 20 MHz clock, asynchronous active high reset
// Notes: Idle counters are measured on the raw pins
`timescale 1ns/1ps
module acrd_detector_props (
	input logic clock,
	input logic rst,
	input logic mclkPin,
	input logic bclkPin,
	input logic lrclkPin,
	input logic pllEnable,
	input logic pllLocked,
	input logic rdEn,
	input logic [7:0] rdAddr,
	input logic wrEn,
	input logic [7:0] wrAddr,
	input logic [7:0] wrData,
	input logic [7:0] rdData_q
);
	logic [11:0] mclkIdle_q;
	logic [11:0] missCnt_q;
	logic mclkPrev_q;
	wire rdRate = rdEn && rdAddr == 8'h5B;
	wire rdHealth = rdEn && rdAddr == 8'h5E;
	// ========================================
	// Idle counters
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mclkIdle_q <= 12'h000;
			missCnt_q <= 12'h000;
			mclkPrev_q <= 1'b0;
		end else begin
			mclkPrev_q <= mclkPin;
			if (mclkPin != mclkPrev_q)
				mclkIdle_q <= 12'h000;
			else if (mclkIdle_q != 12'hFFF)
				mclkIdle_q <= mclkIdle_q + 12'h001;
			if (bclkPin || lrclkPin)
				missCnt_q <= 12'h000;
			else if (missCnt_q != 12'hFFF)
				missCnt_q <= missCnt_q + 12'h001;
		end
	end
	// ========================================
	// Properties
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	chk_unmapped_zero: assert property (
		rdEn && (rdAddr < 8'h5B || rdAddr > 8'h5E) |=> rdData_q == 8'h00)
		else $error("unmapped read not zero");
	chk_reset_zero: assert property (
		$fell(rst) |-> rdData_q == 8'h00) else $error("read data after reset");
	chk_read_hold: assert property (
		!rdEn |=> $stable(rdData_q)) else $error("read data moved");
	chk_pll_unlock: assert property (
		rdHealth && !(pllEnable && pllLocked) |=> rdData_q[5])
		else $error("pll unlock flag missing");
	chk_rate_legal: assert property (
		rdRate |=> rdData_q[6:4] != 3'h7) else $error("rate code illegal");
	chk_ratio_legal: assert property (
		rdRate |=> rdData_q[3:0] <= 4'hD) else $error("ratio code illegal");
	chk_halt_flag: assert property (
		rdHealth && mclkIdle_q >= 12'h03C |=> rdData_q[6])
		else $error("halt flag missing");
	chk_miss_flag: assert property (
		rdHealth && missCnt_q >= 12'h834 |=> rdData_q[4])
		else $error("missing flag absent");
	chk_miss_clears: assert property (
		rdRate && missCnt_q >= 12'h834 |=> rdData_q[6:0] == 7'h00)
		else $error("fields kept without clocks");
endmodule
bind acrd_detector acrd_detector_props u_props (
	.clock(clock),
	.rst(rst),
	.mclkPin(mclkPin),
	.bclkPin(bclkPin),
	.lrclkPin(lrclkPin),
	.pllEnable(pllEnable),
	.pllLocked(pllLocked),
	.rdEn(rdEn),
	.rdAddr(rdAddr),
	.wrEn(wrEn),
	.wrAddr(wrAddr),
	.wrData(wrData),
	.rdData_q(rdData_q)
);

/* File: verification/acrd_host_model.sv */
// Purpose: Audio host making master, bit and frame clocks
// Assumes: Bit clock 400 ns, master clock 200 ns
// Notes: Missing clocks are tied low
`timescale 1ns/1ps
module acrd_host_model (
	input logic run,
	input logic mclkRun,
	input logic [7:0] halfBits,
	output logic mclk,
	output logic bclk,
	output logic lrclk
);
	int n = 0;
	initial begin
		mclk = 1'b0;
		bclk = 1'b0;
		lrclk = 1'b0;
	end
	// 5 MHz master clock, far below the ceiling
	always #100 mclk = mclkRun ? ~mclk : 1'b0;
	always begin
		#200;
		if (!run) begin
			bclk = 1'b0;
			lrclk = 1'b0;
			n = 0;
		end else begin
			bclk = ~bclk;
			if (!bclk) begin
				n = n + 1;
				if (n >= halfBits) begin
					n = 0;
					lrclk = ~lrclk;
				end
			end
		end
	end
endmodule

/* File: verification/testbench.sv */
// Purpose: Register level tests of the audio clock rate detector
// Assumes: 20 MHz clock, host model as clock source
// Notes: 64 bit clocks per frame gives 512 cycles, 128 master clocks
`timescale 1ns/1ps
module testbench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic run = 1'b0;
	logic mclkRun = 1'b1;
	logic [7:0] halfBits = 8'h20;
	logic pllEnable = 1'b1;
	logic pllLocked = 1'b1;
	logic rdEn = 1'b0;
	logic wrEn = 1'b0;
	logic [7:0] rdAddr = 8'h00;
	logic [7:0] wrAddr = 8'h00;
	logic [7:0] wrData = 8'h00;
	logic [7:0] rdData_q;
	logic mclk;
	logic bclk;
	logic lrclk;
	int fails = 0;
	int checked = 0;
	always #25 clock = ~clock;
	acrd_host_model host (.run(run), .mclkRun(mclkRun),
		.halfBits(halfBits), .mclk(mclk), .bclk(bclk), .lrclk(lrclk));
	acrd_detector DUT (.clock(clock), .rst(rst), .mclkPin(mclk),
		.bclkPin(bclk), .lrclkPin(lrclk), .pllEnable(pllEnable),
		.pllLocked(pllLocked), .rdEn(rdEn), .rdAddr(rdAddr), .wrEn(wrEn),
		.wrAddr(wrAddr), .wrData(wrData), .rdData_q(rdData_q));
	// ========================================
	// Access and compare tasks
	task automatic check(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch reg %h expected %h seen %h", a, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge clock);
		rdEn <= 1'b1;
		rdAddr <= a;
		@(posedge clock);
		rdEn <= 1'b0;
		@(posedge clock);
		check(a, e, rdData_q & m);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		wrEn <= 1'b1;
		wrAddr <= a;
		wrData <= d;
		@(posedge clock);
		wrEn <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		fails++;
		report_and_stop();
	end
	// ========================================
	// Tests
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		rd(8'h5B, 8'hFF, 8'h00);
		rd(8'h5D, 8'hFF, 8'h00);
		rd(8'h60, 8'hFF, 8'h00);
		$display("reset test done");
		run <= 1'b1;
		repeat (2500) @(posedge clock);
		rd(8'h5B, 8'hFF, 8'h34);
		rd(8'h5C, 8'hFF, 8'h00);
		rd(8'h5D, 8'hFF, 8'h40);
		rd(8'h5E, 8'hFF, 8'h00);
		pllEnable <= 1'b0;
		repeat (1100) @(posedge clock);
		rd(8'h5E, 8'hFF, 8'h28);
		pllEnable <= 1'b1;
		pllLocked <= 1'b0;
		rd(8'h5E, 8'h20, 8'h20);
		pllLocked <= 1'b1;
		$display("rate test done");
		wr(8'h5B, 8'hFF);
		wr(8'h5C, 8'hFF);
		wr(8'h5D, 8'hFF);
		rd(8'h5B, 8'hFF, 8'hB4);
		rd(8'h5C, 8'hFF, 8'hFE);
		rd(8'h5D, 8'hFF, 8'h40);
		wr(8'h5B, 8'h00);
		wr(8'h5C, 8'h00);
		$display("write test done");
		halfBits <= 8'h08;
		repeat (2000) @(posedge clock);
		rd(8'h5B, 8'hFF, 8'h01);
		rd(8'h5D, 8'hFF, 8'h10);
		rd(8'h5E, 8'hFF, 8'h0A);
		halfBits <= 8'h14;
		repeat (2000) @(posedge clock);
		rd(8'h5B, 8'hFF, 8'h00);
		rd(8'h5D, 8'hFF, 8'h28);
		rd(8'h5E, 8'hFF, 8'h04);
		halfBits <= 8'h80;
		repeat (9000) @(posedge clock);
		rd(8'h5B, 8'hFF, 8'h08);
		rd(8'h5C, 8'hFF, 8'h01);
		rd(8'h5D, 8'hFF, 8'h00);
		rd(8'h5E, 8'hFF, 8'h08);
		$display("ratio sweep test done");
		mclkRun <= 1'b0;
		repeat (200) @(posedge clock);
		rd(8'h5E, 8'h40, 8'h40);
		mclkRun <= 1'b1;
		run <= 1'b0;
		repeat (2200) @(posedge clock);
		rd(8'h5E, 8'h10, 8'h10);
		rd(8'h5B, 8'h7F, 8'h00);
		rd(8'h5D, 8'hFF, 8'h00);
		$display("clock loss test done");
		report_and_stop();
	end
endmodule
